// File: addr_map_decode.v
`timescale 1ns/1ps
`include "cpu_status_defines.vh"

// ****************************************
// Address region decoder
// ****************************************
module addr_map_decode (
   input wire [31:0] ADDR,
   input wire EXPANSION,
   input wire FETCH,
   output reg [2:0] REGION,
   output wire FETCH_FAULT
);
   wire [23:0] phys; // Physical address

   // Upper byte ignored, all images alias
   assign phys = ADDR[23:0] & `PHYS_MASK;

   // Region lookup
   always @* begin
      if (phys <= `ROM_TOP) begin
         REGION = `REGION_ROM;
      end else if (phys >= `PIO_BASE) begin
         REGION = `REGION_PIO;
      end else if (phys >= `RAM_BASE && phys <= `RAM_TOP) begin
         REGION = `REGION_RAM;
      end else if (EXPANSION) begin
         REGION = `REGION_EXT;
      end else begin
         REGION = `REGION_NONE;
      end
   end

   // Fetch attempt into peripheral space
   assign FETCH_FAULT = FETCH && (phys >= `PIO_BASE);
endmodule // addr_map_decode

// File: cpu_status.v
`timescale 1ns/1ps
`include "cpu_status_defines.vh"

// ****************************************
// Cause register, status word, addressing
// ****************************************
module cpu_status (
   input wire CLK,
   input wire RESETN,
   input wire SREG_WR,
   input wire [4:0] SREG_SEL,
   input wire [31:0] SREG_WDATA,
   output reg [31:0] SREG_RDATA,
   input wire NMI_ACCEPT,
   input wire [15:0] NMI_CODE,
   input wire TRAP_ACCEPT,
   input wire IRQ_ACCEPT,
   input wire [15:0] TRAP_IRQ_CODE,
   input wire IRQ_REQ,
   output wire IRQ_TAKE_OK,
   output wire NMI_TAKE_OK,
   input wire FLAGS_WR,
   input wire [31:0] RESULT,
   input wire CARRY_IN,
   input wire OVF_IN,
   input wire CLAMP_OP,
   input wire CLAMP_OVF,
   input wire XSEL_WR,
   input wire XSEL_EXPAND,
   output reg PORT_MODE,
   output reg EXPANSION_ACTIVE,
   input wire PC_LOAD,
   input wire [31:0] BRANCH_BASE,
   input wire [31:0] BRANCH_DISP,
   output reg [31:0] PC,
   input wire [31:0] OPER_BASE,
   input wire [31:0] OPER_DISP,
   output wire [31:0] DATA_ADDR,
   output wire [2:0] DATA_REGION,
   output wire [2:0] FETCH_REGION,
   output reg FETCH_FAULT
);
   reg rst_s1_r; // Reset sync stage 1
   reg rst_s2_r; // Reset sync stage 2
   wire rst_n; // Synchronised reset
   reg [15:0] nmi_cause_code_r; // Upper cause half
   reg [15:0] trap_irq_cause_code_r; // Lower cause half
   reg [31:0] status_word_r; // Status word
   reg [31:0] status_word_nxt;
   reg [31:0] pc_nxt;
   wire fetch_fault_w; // Decoder fetch check
   wire [31:0] cause_register; // Assembled cause

   // ****************************************
   // Reset release
   // ****************************************

   // Two-stage reset synchroniser
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   assign rst_n = rst_s2_r;

   // ****************************************
   // Cause register
   // ****************************************

   // Each acceptance updates only its half
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         nmi_cause_code_r <= `HALF_ZERO;
         trap_irq_cause_code_r <= `HALF_ZERO;
      end else begin
         if (NMI_ACCEPT) begin
            nmi_cause_code_r <= NMI_CODE;
         end
         if (TRAP_ACCEPT || IRQ_ACCEPT) begin
            trap_irq_cause_code_r <= TRAP_IRQ_CODE;
         end
      end
   end
   assign cause_register = {nmi_cause_code_r, trap_irq_cause_code_r};

   // ****************************************
   // Status word
   // ****************************************

   // Next status: software write, then hardware events
   always @* begin
      status_word_nxt = status_word_r;
      // Software store via status register number
      if (SREG_WR && SREG_SEL == `SREG_STATUS) begin
         status_word_nxt = SREG_WDATA;
      end
      // Arithmetic flag update
      if (FLAGS_WR) begin
         status_word_nxt[`SW_CARRY] = CARRY_IN;
         status_word_nxt[`SW_RANGE_ERR] = OVF_IN;
         status_word_nxt[`SW_S] = RESULT[31];
         status_word_nxt[`SW_Z] = (RESULT == `WORD_ZERO);
         // Sticky saturation flag
         if (CLAMP_OP && CLAMP_OVF) begin
            status_word_nxt[`SW_CLAMP] = 1'b1;
         end
      end
      // Exception sets fault flag only
      if (TRAP_ACCEPT) begin
         status_word_nxt[`SW_FAULT] = 1'b1;
      end
      // Maskable interrupt acceptance disables further
      if (IRQ_ACCEPT) begin
         status_word_nxt[`SW_IRQ_DIS] = 1'b1;
      end
      // NMI acceptance sets busy flag
      if (NMI_ACCEPT) begin
         status_word_nxt[`SW_NMI_BUSY] = 1'b1;
         status_word_nxt[`SW_IRQ_DIS] = 1'b1;
      end
      // Reserved bits forced to zero
      status_word_nxt = status_word_nxt & `SW_MASK;
   end

   // Status register
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         status_word_r <= `SW_RESET;
      end else begin
         status_word_r <= status_word_nxt;
      end
   end

   // ****************************************
   // Interrupt acceptance gating
   // ****************************************

   // Maskable: blocked by disable or NMI busy, not by fault flag
   assign IRQ_TAKE_OK = IRQ_REQ && !status_word_r[`SW_IRQ_DIS]
                        && !status_word_r[`SW_NMI_BUSY];
   // NMI: no nesting while busy
   assign NMI_TAKE_OK = !status_word_r[`SW_NMI_BUSY];

   // ****************************************
   // System register read
   // ****************************************

   // Load from selected system register
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         SREG_RDATA <= `WORD_ZERO;
      end else if (SREG_SEL == `SREG_CAUSE) begin
         SREG_RDATA <= cause_register;
      end else if (SREG_SEL == `SREG_STATUS) begin
         SREG_RDATA <= status_word_r & `SW_MASK;
      end else begin
         SREG_RDATA <= `WORD_ZERO;
      end
   end

   // ****************************************
   // Operation mode
   // ****************************************

   // Port mode after reset until expansion selected
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         PORT_MODE <= 1'b1;
         EXPANSION_ACTIVE <= 1'b0;
      end else if (XSEL_WR) begin
         PORT_MODE <= !XSEL_EXPAND;
         EXPANSION_ACTIVE <= XSEL_EXPAND;
      end
   end

   // ****************************************
   // Program counter
   // ****************************************

   // Branch target, wrapped into 24 bits
   always @* begin
      pc_nxt = PC;
      if (PC_LOAD) begin
         pc_nxt = (BRANCH_BASE + BRANCH_DISP) & `PC_MASK;
      end
   end

   // PC starts at reset entry in ROM
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         PC <= `RESET_ENTRY;
         FETCH_FAULT <= 1'b0;
      end else begin
         PC <= pc_nxt;
         FETCH_FAULT <= fetch_fault_w;
      end
   end

   // ****************************************
   // Operand addressing
   // ****************************************

   // 32-bit wrap of operand address
   assign DATA_ADDR = OPER_BASE + OPER_DISP;

   // Data access decoder
   addr_map_decode u_data_dec (
      .ADDR(DATA_ADDR),
      .EXPANSION(EXPANSION_ACTIVE),
      .FETCH(1'b0),
      .REGION(DATA_REGION),
      .FETCH_FAULT()
   );

   // Fetch decoder on current PC
   addr_map_decode u_fetch_dec (
      .ADDR(PC),
      .EXPANSION(EXPANSION_ACTIVE),
      .FETCH(1'b1),
      .REGION(FETCH_REGION),
      .FETCH_FAULT(fetch_fault_w)
   );
endmodule // cpu_status

// File: cpu_status_assertions.sv
`timescale 1ns/1ps
// ***
// Status block checker
// ***
module cpu_status_assertions (
   input wire CLK,
   input wire RESETN,
   input wire SREG_WR,
   input wire [4:0] SREG_SEL,
   input wire [31:0] SREG_RDATA,
   input wire NMI_ACCEPT,
   input wire IRQ_REQ,
   input wire IRQ_TAKE_OK,
   input wire NMI_TAKE_OK,
   input wire FLAGS_WR,
   input wire [31:0] RESULT,
   input wire XSEL_WR,
   input wire EXPANSION_ACTIVE,
   input wire [31:0] PC,
   input wire [31:0] OPER_BASE,
   input wire [31:0] OPER_DISP,
   input wire [31:0] DATA_ADDR
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   pc_top_zero_a:
   assert property (PC[31:24] == 8'h00) else $error("pc top byte nonzero");
   data_wrap_a:
   assert property (DATA_ADDR == OPER_BASE + OPER_DISP) else $error("data address sum wrong");
   nmi_blocks_irq_a:
   assert property (!NMI_TAKE_OK |-> !IRQ_TAKE_OK) else $error("irq taken during nmi");
   irq_needs_req_a:
   assert property (IRQ_TAKE_OK |-> IRQ_REQ) else $error("irq taken with no request");
   zero_sign_a:
   assert property (FLAGS_WR ##1 SREG_SEL == 5'h05 |-> ##1
      SREG_RDATA[1:0] == {$past(RESULT[31], 2), $past(RESULT == 32'h0, 2)})
      else $error("sign or zero flag wrong");
   reserved_zero_a:
   assert property (SREG_SEL == 5'h05 |=> SREG_RDATA[31:8] == 24'h0) else $error("reserved set");
   expand_after_select_a:
   assert property ($rose(EXPANSION_ACTIVE) |-> $past(XSEL_WR)) else $error("expansion unasked");
   nmi_sets_busy_a:
   assert property (NMI_ACCEPT |=> !NMI_TAKE_OK) else $error("nmi busy not set");
endmodule // cpu_status_assertions

bind cpu_status cpu_status_assertions u_chk (.CLK(CLK), .RESETN(RESETN), .SREG_WR(SREG_WR),
   .SREG_SEL(SREG_SEL), .SREG_RDATA(SREG_RDATA), .NMI_ACCEPT(NMI_ACCEPT), .IRQ_REQ(IRQ_REQ),
   .IRQ_TAKE_OK(IRQ_TAKE_OK), .NMI_TAKE_OK(NMI_TAKE_OK), .FLAGS_WR(FLAGS_WR), .RESULT(RESULT),
   .XSEL_WR(XSEL_WR), .EXPANSION_ACTIVE(EXPANSION_ACTIVE), .PC(PC), .OPER_BASE(OPER_BASE),
   .OPER_DISP(OPER_DISP), .DATA_ADDR(DATA_ADDR));

// File: cpu_status_bench.sv
`timescale 1ns/1ps
// ***
// Bench for the status block
// ***
module cpu_status_bench;
   reg CLK = 1'b0, RESETN = 1'b0, SREG_WR = 1'b0, NMI_ACCEPT = 1'b0, TRAP_ACCEPT = 1'b0;
   reg IRQ_ACCEPT = 1'b0, IRQ_REQ = 1'b0, FLAGS_WR = 1'b0, CARRY_IN = 1'b0, OVF_IN = 1'b0;
   reg CLAMP_OP = 1'b0, CLAMP_OVF = 1'b0, XSEL_WR = 1'b0, XSEL_EXPAND = 1'b0, PC_LOAD = 1'b0;
   reg [4:0] SREG_SEL = 5'h05;
   reg [15:0] NMI_CODE = 16'h0, TRAP_IRQ_CODE = 16'h0;
   reg [31:0] SREG_WDATA = 32'h0, RESULT = 32'h0, BRANCH_BASE = 32'h0, BRANCH_DISP = 32'h0;
   reg [31:0] OPER_BASE = 32'h0, OPER_DISP = 32'h0, v;
   wire [31:0] SREG_RDATA, PC, DATA_ADDR;
   wire [2:0] DATA_REGION, FETCH_REGION;
   wire IRQ_TAKE_OK, NMI_TAKE_OK, PORT_MODE, EXPANSION_ACTIVE, FETCH_FAULT;
   integer failures = 0, total_checks = 0, i;
   // Flag rows: result, then {clamp ovf, carry, ovf, expected low five bits}
   reg [31:0] res_t [0:5] = '{32'h0, 32'h80000000, 32'h5, 32'hFFFFFFFF, 32'h1, 32'h0};
   reg [7:0] ctl_t [0:5] = '{8'h49, 8'h26, 8'h00, 8'h6E, 8'h90, 8'h11};
   cpu_status u_dut (.CLK(CLK), .RESETN(RESETN), .SREG_WR(SREG_WR), .SREG_SEL(SREG_SEL),
      .SREG_WDATA(SREG_WDATA), .SREG_RDATA(SREG_RDATA), .NMI_ACCEPT(NMI_ACCEPT),
      .NMI_CODE(NMI_CODE), .TRAP_ACCEPT(TRAP_ACCEPT), .IRQ_ACCEPT(IRQ_ACCEPT),
      .TRAP_IRQ_CODE(TRAP_IRQ_CODE), .IRQ_REQ(IRQ_REQ), .IRQ_TAKE_OK(IRQ_TAKE_OK),
      .NMI_TAKE_OK(NMI_TAKE_OK), .FLAGS_WR(FLAGS_WR), .RESULT(RESULT), .CARRY_IN(CARRY_IN),
      .OVF_IN(OVF_IN), .CLAMP_OP(CLAMP_OP), .CLAMP_OVF(CLAMP_OVF), .XSEL_WR(XSEL_WR),
      .XSEL_EXPAND(XSEL_EXPAND),
      .PORT_MODE(PORT_MODE), .EXPANSION_ACTIVE(EXPANSION_ACTIVE), .PC_LOAD(PC_LOAD),
      .BRANCH_BASE(BRANCH_BASE), .BRANCH_DISP(BRANCH_DISP), .PC(PC), .OPER_BASE(OPER_BASE),
      .OPER_DISP(OPER_DISP), .DATA_ADDR(DATA_ADDR), .DATA_REGION(DATA_REGION),
      .FETCH_REGION(FETCH_REGION), .FETCH_FAULT(FETCH_FAULT));
   // 50 MHz clock
   always #10 CLK = ~CLK;
   // Compare and count
   task chk(input [31:0] s, input [31:0] e);
      total_checks = total_checks + 1;
      if (s !== e) begin
         failures = failures + 1;
         $display("mismatch %0t seen %h want %h", $time, s, e);
      end
   endtask
   // Verdict and end of run
   task report_and_stop;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Store strobe, one cycle
   task wr(input [4:0] n, input [31:0] d);
      @(posedge CLK); SREG_WR <= 1'b1; SREG_SEL <= n; SREG_WDATA <= d;
      @(posedge CLK); SREG_WR <= 1'b0;
   endtask
   // Load: select, then registered answer
   task rd(input [4:0] n);
      @(posedge CLK); SREG_SEL <= n;
      @(posedge CLK); #1 v = SREG_RDATA;
   endtask
   // Hang guard
   initial begin
      #1000000 failures = failures + 1;
      report_and_stop;
   end
   // ***
   // Main sequence
   // ***
   initial begin
      repeat (20) @(posedge CLK);
      RESETN <= 1'b1;
      repeat (3) @(posedge CLK);
      #1 chk(PC, 32'h0); chk(PORT_MODE, 1); chk(EXPANSION_ACTIVE, 0);
      rd(5'h04); chk(v, 32'h0);
      rd(5'h06); chk(v, 32'h0);
      rd(5'h05); chk(v, 32'h20);
      @(posedge CLK); IRQ_REQ <= 1'b1; CLAMP_OP <= 1'b1;
      @(posedge CLK); #1 chk(IRQ_TAKE_OK, 0);
      for (i = 0; i < 6; i = i + 1) begin
         @(posedge CLK); FLAGS_WR <= 1'b1; RESULT <= res_t[i];
         {CLAMP_OVF, CARRY_IN, OVF_IN} <= ctl_t[i][7:5];
         @(posedge CLK); FLAGS_WR <= 1'b0;
         rd(5'h05); chk(v[4:0], ctl_t[i][4:0]);
      end
      wr(5'h05, 32'hFFFFFFFF); rd(5'h05); chk(v, 32'hFF);
      wr(5'h05, 32'h0); rd(5'h05); chk(IRQ_TAKE_OK, 1);
      wr(5'h04, 32'h12345678); rd(5'h04); chk(v, 32'h0);
      @(posedge CLK); NMI_ACCEPT <= 1'b1; NMI_CODE <= 16'hA5C3;
      @(posedge CLK); NMI_ACCEPT <= 1'b0; TRAP_ACCEPT <= 1'b1; TRAP_IRQ_CODE <= 16'h0040;
      @(posedge CLK); TRAP_ACCEPT <= 1'b0;
      #1 chk({NMI_TAKE_OK, IRQ_TAKE_OK}, 0);
      rd(5'h04); chk(v, 32'hA5C30040);
      rd(5'h05); chk(v[7:6], 2'h3);
      wr(5'h05, 32'h40); rd(5'h05); chk(IRQ_TAKE_OK, 1);
      @(posedge CLK); PC_LOAD <= 1'b1; BRANCH_BASE <= 32'h00FFFFF0; BRANCH_DISP <= 32'h20;
      @(posedge CLK); PC_LOAD <= 1'b0;
      #1 chk(PC, 32'h10);
      @(posedge CLK); PC_LOAD <= 1'b1; BRANCH_BASE <= 32'h00FFF000; BRANCH_DISP <= 32'h0;
      @(posedge CLK); PC_LOAD <= 1'b0;
      repeat (2) @(posedge CLK);
      #1 chk(FETCH_FAULT, 1); chk(FETCH_REGION, 3'h2);
      @(posedge CLK); OPER_BASE <= 32'hFFFFFFF0; OPER_DISP <= 32'h20;
      @(posedge CLK); #1 chk(DATA_ADDR, 32'h10); chk(DATA_REGION, 3'h0);
      @(posedge CLK); OPER_BASE <= 32'h05FFF000; OPER_DISP <= 32'h0;
      @(posedge CLK); #1 chk(DATA_REGION, 3'h2);
      @(posedge CLK); OPER_BASE <= 32'h00FF8000;
      @(posedge CLK); #1 chk(DATA_REGION, 3'h1);
      // Software stays inside the smallest fitted ROM
      @(posedge CLK); OPER_BASE <= 32'h07020000;
      @(posedge CLK); #1 chk(DATA_REGION, 3'h0);
      @(posedge CLK); OPER_BASE <= 32'hFF100000;
      @(posedge CLK); #1 chk(DATA_REGION, 3'h4);
      @(posedge CLK); XSEL_WR <= 1'b1; XSEL_EXPAND <= 1'b1;
      @(posedge CLK); XSEL_WR <= 1'b0;
      @(posedge CLK); #1 chk(EXPANSION_ACTIVE, 1); chk(DATA_REGION, 3'h3);
      // Mid-run reset returns everything to its start values
      @(posedge CLK); RESETN <= 1'b0;
      repeat (3) @(posedge CLK);
      #1 chk(EXPANSION_ACTIVE, 0); chk(PORT_MODE, 1); chk(PC, 32'h0);
      @(posedge CLK); RESETN <= 1'b1;
      @(posedge CLK); #1 chk(PC, 32'h0); chk(EXPANSION_ACTIVE, 0);
      repeat (2) @(posedge CLK);
      rd(5'h05); chk(v, 32'h20);
      rd(5'h04); chk(v, 32'h0);
      report_and_stop;
   end
endmodule // cpu_status_bench

// File: cpu_status_defines.vh
`ifndef CPU_STATUS_DEFINES_VH
`define CPU_STATUS_DEFINES_VH

// ****************************************
// System register numbers
// ****************************************
`define SREG_CAUSE 5'h04
`define SREG_STATUS 5'h05

// ****************************************
// Status word layout
// ****************************************
`define SW_RESET 32'h00000020
`define SW_Z 0
`define SW_S 1
`define SW_RANGE_ERR 2
`define SW_CARRY 3
`define SW_CLAMP 4
`define SW_IRQ_DIS 5
`define SW_FAULT 6
`define SW_NMI_BUSY 7
`define SW_MASK 32'h000000FF
`define WORD_ZERO 32'h00000000

// ****************************************
// Cause register layout
// ****************************************
`define CAUSE_RESET 32'h00000000
`define HALF_ZERO 16'h0000

// ****************************************
// Address map
// ****************************************
`define PC_MASK 32'h00FFFFFE
`define PHYS_MASK 24'hFFFFFF
`define ROM_TOP 24'h0FFFFF
`define RAM_BASE 24'hFF8000
`define RAM_TOP 24'hFFEFFF
`define PIO_BASE 24'hFFF000
`define RESET_ENTRY 32'h00000000
`define REGION_ROM 3'h0
`define REGION_RAM 3'h1
`define REGION_PIO 3'h2
`define REGION_EXT 3'h3
`define REGION_NONE 3'h4

`endif
